// File: verilog/video_timer_params.svh
// Constants of the video timer command port: command codes, register indices, field positions.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef VIDEO_TIMER_PARAMS_SVH
`define VIDEO_TIMER_PARAMS_SVH

// ==========================================================
// Select line command codes (bit 3 is the first select line)
`define VT_CMD_LAST_FMT 4'h6
`define VT_CMD_PSL 4'h7
`define VT_CMD_RD_ROW 4'h8
`define VT_CMD_RD_CHAR 4'h9
`define VT_CMD_RESET 4'hA
`define VT_CMD_SCROLL 4'hB
`define VT_CMD_LD_CHAR 4'hC
`define VT_CMD_LD_ROW 4'hD
`define VT_CMD_START 4'hE
`define VT_CMD_SSL 4'hF

// ==========================================================
// Formatting register indices
`define VT_NFMT 7
`define VT_REG_HTOTAL 3'h0
`define VT_REG_SCANS 3'h2
`define VT_REG_ROWS 3'h3
`define VT_REG_LASTROW 3'h6
`define VT_LOAD_LAST 3'h6

// ==========================================================
// Field positions and reset values
`define VT_SCANS_HI 6
`define VT_SCANS_LO 3
`define VT_ROW_HI 5
`define VT_REG_RST 8'h00
`define VT_ROW_RST 6'h00

`endif

// File: verilog/video_timer_pkg.sv
// Types shared by the video timer command port.
// Assumes nothing of its surroundings.
package video_timer_pkg;
	typedef enum logic [2:0] {ST_HELD, ST_START_WAIT, ST_RUN, ST_PSL_LOAD, ST_PSL_IDLE, ST_SSL_LOAD} state_t;
	typedef logic [7:0] byte_t;
endpackage

// File: verilog/format_reg_bank.sv
// Bank of write-only formatting registers with registered outputs.
// Assumes one write port driven from the command decoder or the self-load sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "video_timer_params.svh"
module format_reg_bank #(
	parameter int NREG = `VT_NFMT,
	parameter int W = 8
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_we,
	input wire logic [2:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	output logic [NREG*W-1:0] o_regs
);
	generate
		if (NREG < 1 || NREG > 8)
		begin : g_chk
			$error("format_reg_bank: NREG must be 1 to 8");
		end
	endgenerate

	// ==========================================================
	// One flop word per register
	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_reg
			always_ff @(posedge i_mclk)
			begin
				if (!i_nrst)
					o_regs[g*W +: W] <= W'(`VT_REG_RST);
				else if (i_we && i_waddr == 3'(g))
					o_regs[g*W +: W] <= i_wdata;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: verilog/timing_counters.sv
// Character column, scan and data row counters with scroll offset.
// Assumes i_tick is a one-cycle character clock enable and i_hold freezes at top left.
`timescale 1ns/1ps
`default_nettype none
`include "video_timer_params.svh"
module timing_counters (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_tick,
	input wire logic i_hold,
	input wire logic i_scroll,
	input wire logic [7:0] i_htotal,
	input wire logic [3:0] i_scans_m1,
	input wire logic [5:0] i_rows_m1,
	input wire logic [5:0] i_last_row,
	output logic [7:0] o_col,
	output logic [3:0] o_scan,
	output logic [5:0] o_row
);
	logic [5:0] first_row_r;
	logic [5:0] row_idx_r;

	function automatic logic [5:0] wrap_inc(input logic [5:0] v, input logic [5:0] last);
		wrap_inc = (v >= last) ? 6'h00 : v + 6'h01;
	endfunction

	// ==========================================================
	// First displayed row, advanced by scroll
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			first_row_r <= `VT_ROW_RST;
		else if (i_scroll)
			first_row_r <= wrap_inc(first_row_r, i_last_row);
	end

	// ==========================================================
	// Counter chain
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst || i_hold)
		begin
			o_col <= 8'h00;
			o_scan <= 4'h0;
			row_idx_r <= 6'h00;
			o_row <= first_row_r;
		end
		else if (i_tick)
		begin
			o_col <= (o_col == i_htotal) ? 8'h00 : o_col + 8'h01;
			if (o_col == i_htotal)
			begin
				o_scan <= (o_scan == i_scans_m1) ? 4'h0 : o_scan + 4'h1;
				if (o_scan == i_scans_m1)
				begin
					if (row_idx_r == i_rows_m1)
					begin
						row_idx_r <= 6'h00;
						o_row <= first_row_r;
					end
					else
					begin
						row_idx_r <= row_idx_r + 6'h01;
						o_row <= wrap_inc(o_row, i_last_row);
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: verilog/video_timer_cmd_port.sv
// Command and control port of a character video timer, with cursor compare.
// Assumes synchronous inputs, a character clock enable, and an external PROM on the byte bus.
//
// What this block does
// - Codes 0 to 6 on a strobe load the byte bus into formatting registers.
// - Code 8 drives cursor row, code 9 cursor character, onto the byte bus.
// - Code 12 writes cursor character, code 13 writes cursor row, from the bus.
// - Reset code latched by strobe sends chain to top left and freezes counters.
// - After reset the chain stays parked until a start command arrives or stand-alone self-load ends.
// - Start releases the timing chain about one scan line later.
// - Code 7 enters processor self-load, loading registers from the PROM.
// - Processor self-load idles after loading and ends on a start, reset or code 15 strobe.
// - During self-load PROM addresses go out on the row lines; bytes are stored.
// - Code 15 begins stand-alone self-load when the strobe goes low.
// - Removing code 15 ends stand-alone self-load; timing starts one line later.
// - Scroll code 11 advances the first displayed row, wrapping at the page.
// - Cursor character position is an eight-bit register.
// - Cursor row position is a six-bit register.
// - Cursor pulse when the chain runs and column and row counters match the cursor registers.
// - Strobed commands and reads act only with chip select; self-load stores and the code 15 exit ignore it.
`timescale 1ns/1ps
`default_nettype none
`include "video_timer_params.svh"
module video_timer_cmd_port (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_chip_sel,
	input wire logic [3:0] i_command_select_lines,
	input wire logic i_data_strobe_n,
	input wire logic [7:0] i_host_byte_bus,
	output logic [7:0] o_host_byte_bus,
	output logic o_host_byte_bus_oe,
	input wire logic i_char_tick,
	output logic [7:0] o_char_column_lines,
	output logic [5:0] o_data_row_lines,
	output logic [3:0] o_scan_count,
	output logic o_cursor_video_pulse,
	output logic o_timing_run,
	output logic o_self_load
);
	video_timer_pkg::state_t st_r;
	video_timer_pkg::state_t st_nxt;
	logic ds_n_r;
	logic fire;
	logic [3:0] cmd;
	logic loading;
	logic [2:0] load_addr_r;
	logic [7:0] line_cnt_r;
	video_timer_pkg::byte_t cur_char_r;
	logic [5:0] cur_row_r;
	logic bank_we;
	logic [2:0] bank_waddr;
	logic [`VT_NFMT*8-1:0] regs;
	logic [7:0] htotal;
	logic [3:0] scans_m1;
	logic [5:0] rows_m1;
	logic [5:0] last_row;
	logic [7:0] col;
	logic [5:0] row;
	logic [3:0] scan;

	function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] code);
		is_cmd = (c == code);
	endfunction

	function automatic logic is_read(input logic [3:0] c);
		is_read = is_cmd(c, `VT_CMD_RD_ROW) || is_cmd(c, `VT_CMD_RD_CHAR);
	endfunction

	// ==========================================================
	// Strobe edge and chip select gating
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			ds_n_r <= 1'b1;
		else
			ds_n_r <= i_data_strobe_n;
	end

	assign cmd = i_command_select_lines;
	assign fire = i_chip_sel && ds_n_r && !i_data_strobe_n;

	// ==========================================================
	// Run control state machine
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			video_timer_pkg::ST_RUN:
				st_nxt = st_r;
			video_timer_pkg::ST_HELD:
				if (fire && is_cmd(cmd, `VT_CMD_START))
					st_nxt = video_timer_pkg::ST_START_WAIT;
			video_timer_pkg::ST_START_WAIT:
				if (i_char_tick && line_cnt_r == htotal)
					st_nxt = video_timer_pkg::ST_RUN;
			video_timer_pkg::ST_PSL_LOAD:
				if (fire && is_cmd(cmd, `VT_CMD_START))
					st_nxt = video_timer_pkg::ST_START_WAIT;
				else if (i_char_tick && o_self_load && load_addr_r == `VT_LOAD_LAST)
					st_nxt = video_timer_pkg::ST_PSL_IDLE;
			video_timer_pkg::ST_PSL_IDLE:
				if (fire && is_cmd(cmd, `VT_CMD_START))
					st_nxt = video_timer_pkg::ST_START_WAIT;
			video_timer_pkg::ST_SSL_LOAD:
				if (!is_cmd(cmd, `VT_CMD_SSL))
					st_nxt = video_timer_pkg::ST_START_WAIT;
			default:
				st_nxt = video_timer_pkg::ST_HELD;
		endcase
		if (st_r != video_timer_pkg::ST_SSL_LOAD)
		begin
			if (fire && is_cmd(cmd, `VT_CMD_RESET))
				st_nxt = video_timer_pkg::ST_HELD;
			else if (fire && is_cmd(cmd, `VT_CMD_PSL))
				st_nxt = video_timer_pkg::ST_PSL_LOAD;
			else if (fire && is_cmd(cmd, `VT_CMD_SSL))
				st_nxt = video_timer_pkg::ST_SSL_LOAD;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			st_r <= video_timer_pkg::ST_HELD;
		else
			st_r <= st_nxt;
	end

	// ==========================================================
	// One scan line delay before release
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst || st_r != video_timer_pkg::ST_START_WAIT)
			line_cnt_r <= 8'h00;
		else if (i_char_tick)
			line_cnt_r <= line_cnt_r + 8'h01;
	end

	// ==========================================================
	// Self-load address sequencer
	assign loading = (st_r == video_timer_pkg::ST_PSL_LOAD) || (st_r == video_timer_pkg::ST_SSL_LOAD);

	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst || !loading)
			load_addr_r <= 3'h0;
		else if (i_char_tick && o_self_load)
			load_addr_r <= (load_addr_r == `VT_LOAD_LAST) ? 3'h0 : load_addr_r + 3'h1;
	end

	// ==========================================================
	// Formatting register writes
	always_comb
	begin
		bank_we = 1'b0;
		bank_waddr = cmd[2:0];
		if (loading)
		begin
			// Store only once the address already stands on the row lines
			bank_we = i_char_tick && o_self_load;
			bank_waddr = load_addr_r;
		end
		else if (fire && cmd <= `VT_CMD_LAST_FMT)
			bank_we = 1'b1;
	end

	format_reg_bank #(
		.NREG(`VT_NFMT),
		.W(8)
	) u_bank (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_we(bank_we),
		.i_waddr(bank_waddr),
		.i_wdata(i_host_byte_bus),
		.o_regs(regs)
	);

	assign htotal = regs[`VT_REG_HTOTAL*8 +: 8];
	assign scans_m1 = regs[`VT_REG_SCANS*8+`VT_SCANS_LO +: 4];
	assign rows_m1 = regs[`VT_REG_ROWS*8 +: 6];
	assign last_row = regs[`VT_REG_LASTROW*8 +: 6];

	// ==========================================================
	// Cursor registers
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			cur_char_r <= `VT_REG_RST;
		else if (fire && is_cmd(cmd, `VT_CMD_LD_CHAR))
			cur_char_r <= i_host_byte_bus;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			cur_row_r <= `VT_ROW_RST;
		else if (fire && is_cmd(cmd, `VT_CMD_LD_ROW))
			cur_row_r <= i_host_byte_bus[`VT_ROW_HI:0];
	end

	// ==========================================================
	// Byte bus read drive
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			o_host_byte_bus <= 8'h00;
		else if (is_cmd(cmd, `VT_CMD_RD_ROW))
			o_host_byte_bus <= {2'h0, cur_row_r};
		else
			o_host_byte_bus <= cur_char_r;
	end

	assign o_host_byte_bus_oe = i_chip_sel && !i_data_strobe_n && is_read(cmd) && !loading;

	// ==========================================================
	// Timing chain
	timing_counters u_cnt (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_tick(i_char_tick),
		.i_hold(st_r != video_timer_pkg::ST_RUN),
		.i_scroll(fire && is_cmd(cmd, `VT_CMD_SCROLL)),
		.i_htotal(htotal),
		.i_scans_m1(scans_m1),
		.i_rows_m1(rows_m1),
		.i_last_row(last_row),
		.o_col(col),
		.o_scan(scan),
		.o_row(row)
	);

	// ==========================================================
	// Registered outputs and cursor compare
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			o_char_column_lines <= 8'h00;
			o_data_row_lines <= 6'h00;
			o_scan_count <= 4'h0;
		end
		else
		begin
			o_char_column_lines <= col;
			o_data_row_lines <= loading ? {3'h0, load_addr_r} : row;
			o_scan_count <= scan;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			o_cursor_video_pulse <= 1'b0;
		else
			o_cursor_video_pulse <= (st_r == video_timer_pkg::ST_RUN) && col == cur_char_r && row == cur_row_r;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			o_timing_run <= 1'b0;
			o_self_load <= 1'b0;
		end
		else
		begin
			o_timing_run <= st_nxt == video_timer_pkg::ST_RUN;
			o_self_load <= loading;
		end
	end

	// ==========================================================
	// Assertions
	sequence s_start_cmd;
		fire && is_cmd(cmd, `VT_CMD_START);
	endsequence

	sequence s_reset_cmd;
		fire && is_cmd(cmd, `VT_CMD_RESET) && st_r != video_timer_pkg::ST_SSL_LOAD;
	endsequence

	a_fmt_load: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		fire && cmd == 4'h3 && !loading |=> rows_m1 == $past(i_host_byte_bus[5:0]))
		else $error("format register not loaded");
	a_read_drive: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		i_chip_sel && !i_data_strobe_n && is_cmd(cmd, `VT_CMD_RD_CHAR) && $past(cmd) == `VT_CMD_RD_CHAR
		&& !loading |-> o_host_byte_bus_oe && o_host_byte_bus == $past(cur_char_r))
		else $error("cursor read not driven");
	a_read_row: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		i_chip_sel && !i_data_strobe_n && is_cmd(cmd, `VT_CMD_RD_ROW) && $past(cmd) == `VT_CMD_RD_ROW
		&& !loading |-> o_host_byte_bus_oe && o_host_byte_bus == {2'h0, $past(cur_row_r)})
		else $error("cursor row read not driven");
	a_cur_char: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		fire && is_cmd(cmd, `VT_CMD_LD_CHAR) |=> cur_char_r == $past(i_host_byte_bus))
		else $error("cursor character not written");
	a_cur_row: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		fire && is_cmd(cmd, `VT_CMD_LD_ROW) |=> cur_row_r == $past(i_host_byte_bus[5:0]))
		else $error("cursor row not written");
	a_reset_freeze: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		s_reset_cmd |=> st_r == video_timer_pkg::ST_HELD ##1 col == 8'h00 && scan == 4'h0)
		else $error("reset did not freeze chain");
	a_held_park: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		st_r == video_timer_pkg::ST_HELD && !fire |=> st_r == video_timer_pkg::ST_HELD)
		else $error("left reset without start");
	a_start_delay: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		st_r == video_timer_pkg::ST_HELD ##0 s_start_cmd |=> !o_timing_run [*2])
		else $error("chain released without line delay");
	a_psl_idle: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		st_r == video_timer_pkg::ST_PSL_IDLE && !fire |=> st_r == video_timer_pkg::ST_PSL_IDLE)
		else $error("processor self-load left without start");
	a_prom_addr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		loading |=> o_data_row_lines == {3'h0, $past(load_addr_r)})
		else $error("PROM address missing on row lines");
	a_ssl_end: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		st_r == video_timer_pkg::ST_SSL_LOAD && !is_cmd(cmd, `VT_CMD_SSL) |=> st_r == video_timer_pkg::ST_START_WAIT)
		else $error("stand-alone self-load not ended");
	a_cs_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!i_chip_sel |-> !fire && !o_host_byte_bus_oe)
		else $error("acted without chip select");
	a_cursor_hit: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		st_r == video_timer_pkg::ST_RUN && col == cur_char_r && row == cur_row_r |=> o_cursor_video_pulse)
		else $error("cursor pulse missing");
	a_cs_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!i_chip_sel |=> $stable(cur_char_r) && $stable(cur_row_r))
		else $error("cursor changed without chip select");
	a_prom_step: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		bank_we && loading |-> o_data_row_lines == {3'h0, load_addr_r})
		else $error("PROM byte stored for wrong address");
	a_ssl_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		st_r == video_timer_pkg::ST_SSL_LOAD && is_cmd(cmd, `VT_CMD_SSL) |=> st_r == video_timer_pkg::ST_SSL_LOAD)
		else $error("stand-alone self-load left early");
endmodule
`default_nettype wire

// File: tb/prom_model.sv
// Control PROM model that feeds the timer during self-load.
// Assumes the bench routes o_q onto the byte bus only while i_en is high.
`timescale 1ns/1ps
`default_nettype none
module prom_model (
	input wire logic [5:0] i_addr,
	input wire logic i_en,
	output logic [7:0] o_q
);
	// ==========================================================
	// Contents: six characters a line, two scans a row, four rows
	function automatic logic [7:0] rom(input logic [5:0] a);
		case (a)
			6'h00: return 8'h05;
			6'h02: return 8'h08;
			6'h03, 6'h06: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction
	logic [7:0] last_q = 8'h00;
	// Answers straight from the row lines; released output shows the inverse
	always @(i_addr or i_en)
		if (i_en)
			last_q = rom(i_addr);
	assign o_q = i_en ? rom(i_addr) : ~last_q;
endmodule
`default_nettype wire

// File: tb/tb.sv
// Testbench of the video timer command port.
// Assumes the design and prom_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "video_timer_params.svh"
module tb;
	logic i_mclk = 1'b0;
	logic i_nrst = 1'b0;
	logic cs = 1'b0;
	logic [3:0] code = 4'h0;
	logic ds_n = 1'b1;
	logic [7:0] host_d = 8'h00;
	logic tick = 1'b0;
	logic [1:0] div = 2'h0;
	logic prom_on = 1'b0;
	logic [7:0] prom_q, bus_out, bus_in, col, rd, col_max;
	logic bus_oe, pulse, run, sl;
	logic [5:0] row, addr_max;
	logic [3:0] scan;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	logic [7:0] fmt [7] = '{8'h07, 8'h00, 8'h08, 8'h03, 8'h00, 8'h00, 8'h03};
	assign bus_in = bus_oe ? bus_out : (prom_on ? prom_q : host_d);
	video_timer_cmd_port DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_chip_sel(cs),
		.i_command_select_lines(code), .i_data_strobe_n(ds_n), .i_host_byte_bus(bus_in),
		.o_host_byte_bus(bus_out), .o_host_byte_bus_oe(bus_oe), .i_char_tick(tick),
		.o_char_column_lines(col), .o_data_row_lines(row), .o_scan_count(scan),
		.o_cursor_video_pulse(pulse), .o_timing_run(run), .o_self_load(sl));
	prom_model prom (.i_addr(row), .i_en(prom_on), .o_q(prom_q));
	initial forever #10 i_mclk = ~i_mclk;
	// ==========================================================
	// Character tick every fourth cycle, span monitors, timeout
	always @(posedge i_mclk)
	begin
		div <= div + 2'h1;
		tick <= (div == 2'h3);
		cyc <= cyc + 1;
		if (run === 1'b1 && col > col_max)
			col_max <= col;
		if (prom_on && row > addr_max)
			addr_max <= row;
		if (cyc == 8000)
		begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	// ==========================================================
	// Port access: code set a cycle ahead, strobe low for one cycle
	task automatic cmd(input logic c_cs, input logic [3:0] c, input logic [7:0] d);
		@(posedge i_mclk);
		cs <= c_cs;
		code <= c;
		host_d <= d;
		ds_n <= 1'b1;
		@(posedge i_mclk);
		ds_n <= 1'b0;
		@(posedge i_mclk);
		ds_n <= 1'b1;
		host_d <= ~d;
		cs <= 1'b1;
	endtask
	task automatic rd_cur(input logic [3:0] c, output logic [7:0] v);
		@(posedge i_mclk);
		cs <= 1'b1;
		code <= c;
		ds_n <= 1'b1;
		@(posedge i_mclk);
		ds_n <= 1'b0;
		#1;
		v = bus_oe ? bus_out : 8'hXX;
		@(posedge i_mclk);
		ds_n <= 1'b1;
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	task automatic wait_run(input int lim);
		n = 0;
		while (run !== 1'b1 && n < lim)
		begin
			idle(1);
			n++;
		end
	endtask
	// ==========================================================
	// Test sequence
	initial
	begin
		col_max = 8'h00;
		addr_max = 6'h00;
		repeat (5) @(posedge i_mclk);
		i_nrst <= 1'b1;
		idle(2);
		chk_bit("run after reset", 1'b0, run);
		chk_bit("self load after reset", 1'b0, sl);
		rd_cur(`VT_CMD_RD_CHAR, rd);
		chk_val("char reset", 8'h00, rd);
		cmd(1'b1, `VT_CMD_LD_CHAR, 8'hA5);
		cmd(1'b1, `VT_CMD_LD_ROW, 8'hEB);
		rd_cur(`VT_CMD_RD_CHAR, rd);
		chk_val("cursor char", 8'hA5, rd);
		rd_cur(`VT_CMD_RD_ROW, rd);
		chk_val("cursor row", 8'h2B, rd);
		cmd(1'b0, `VT_CMD_LD_CHAR, 8'h5A);
		rd_cur(`VT_CMD_RD_CHAR, rd);
		chk_val("char unselected", 8'hA5, rd);
		for (int i = 0; i < 7; i++)
			cmd(1'b1, 4'(i), fmt[i]);
		idle(200);
		chk_bit("held until start", 1'b0, run);
		chk_val("column held", 8'h00, col);
		cmd(1'b1, `VT_CMD_SCROLL, 8'h00);
		// No dot counter pin here, so start needs no extra hold
		cmd(1'b1, `VT_CMD_START, 8'h00);
		wait_run(100);
		chk_bit("start latency", 1'b1, n >= 28 && n <= 40);
		chk_val("first row scrolled", 8'h01, {2'b00, row});
		col_max = 8'h00;
		cmd(1'b1, `VT_CMD_LD_CHAR, 8'h03);
		cmd(1'b1, `VT_CMD_LD_ROW, 8'h01);
		idle(300);
		chk_val("column span", 8'h07, col_max);
		n = 0;
		while (pulse !== 1'b1 && n < 600)
		begin
			idle(1);
			n++;
		end
		chk_bit("pulse seen", 1'b1, pulse);
		chk_val("pulse column", 8'h03, col);
		chk_val("pulse row", 8'h01, {2'b00, row});
		cmd(1'b1, `VT_CMD_RESET, 8'h00);
		idle(3);
		chk_bit("run after reset code", 1'b0, run);
		idle(40);
		chk_val("column parked", 8'h00, col);
		chk_val("scan parked", 8'h00, {4'h0, scan});
		prom_on = 1'b1;
		addr_max = 6'h00;
		cmd(1'b1, `VT_CMD_PSL, 8'h00);
		idle(100);
		chk_val("prom address span", 8'h06, {2'b00, addr_max});
		chk_bit("idle after load", 1'b0, run);
		prom_on = 1'b0;
		cmd(1'b1, `VT_CMD_START, 8'h00);
		wait_run(100);
		chk_bit("run after start", 1'b1, run);
		col_max = 8'h00;
		idle(100);
		chk_val("span from prom", 8'h05, col_max);
		cmd(1'b1, `VT_CMD_RESET, 8'h00);
		cmd(1'b1, 4'h0, 8'h07);
		prom_on <= 1'b1;
		cmd(1'b1, `VT_CMD_SSL, 8'h00);
		// Code held over several full load cycles
		idle(100);
		chk_bit("stand-alone loading", 1'b1, sl);
		@(posedge i_mclk);
		// Withdrawn on a clock edge; no dot carry pin to hold
		code <= `VT_CMD_RD_ROW;
		wait_run(100);
		chk_bit("start after withdraw", 1'b1, n >= 18 && n <= 32);
		prom_on = 1'b0;
		col_max = 8'h00;
		idle(100);
		chk_val("span stand-alone", 8'h05, col_max);
		test_done();
	end
endmodule
`default_nettype wire
